// file: pkg/msc_pkg.sv
// Constants shared by the segment control framer and its command classifier.
// These files assume one clock domain and an active low synchronous reset.
package msc_pkg;

  // Segment control field geometry, byte 0.
  localparam int SC_OCTETS = 3;
  localparam int RSV_HI = 7;
  localparam int RSV_LO = 4;
  localparam int TMR_BIT = 3;
  localparam int CC_BIT = 2;
  localparam int CAP_BIT = 1;
  localparam int LSF_BIT = 0;

  // Segment control field geometry, bytes 1 and 2.
  localparam int CNT_W = 6;
  localparam int CNT_HI = 7;
  localparam int CNT_LO = 2;
  localparam int LEN_W = 10;
  localparam int LEN_LO_W = 8;
  localparam int LEN_TOP_HI = 1;
  localparam int LEN_TOP_LO = 0;

  // Command identifiers the device may send or act on.
  localparam logic [7:0] CMD_BEACON_REQ = 8'h07;
  localparam logic [7:0] CMD_TONE_MAP_RESP = 8'h0a;

  localparam logic [3:0] RSV_ZERO = 4'h0;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_CHECK = 3'b001,
    TX_SC0   = 3'b010,
    TX_SC1   = 3'b011,
    TX_SC2   = 3'b100,
    TX_BODY  = 3'b101
  } msc_tx_state_t;

  typedef enum logic [1:0] {
    RX_SC0  = 2'b00,
    RX_SC1  = 2'b01,
    RX_SC2  = 2'b10,
    RX_BODY = 2'b11
  } msc_rx_state_t;

endpackage

// file: core/msc_cmd_class.sv
// Command identifier classifier with registered one-cycle result pulses.
// Assumes the caller presents one identifier per valid cycle.
`timescale 1ns/1ps
`default_nettype none

module msc_cmd_class (
  input wire logic clk_i,        // Clock.
  input wire logic rst_n_i,      // Synchronous reset, active low.
  input wire logic valid_i,      // Identifier present this cycle.
  input wire logic [7:0] id_i,   // Command identifier.
  output logic beacon_o,         // Pulse: beacon request seen.
  output logic tone_map_o,       // Pulse: tone-map response seen.
  output logic supported_o,      // Pulse: identifier is on the list.
  output logic unsupported_o     // Pulse: identifier is not allowed.
);

  // Only two commands are on the list; association, orphan, data request,
  // realignment, conflict and slot requests all fall out as unsupported.
  wire is_beacon = (id_i == msc_pkg::CMD_BEACON_REQ);
  wire is_tmap = (id_i == msc_pkg::CMD_TONE_MAP_RESP);
  wire is_ok = is_beacon | is_tmap;

  // Results are registered so they leave as clean flop outputs.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      beacon_o <= 1'b0;
      tone_map_o <= 1'b0;
      supported_o <= 1'b0;
      unsupported_o <= 1'b0;
    end else begin
      beacon_o <= valid_i & is_beacon;
      tone_map_o <= valid_i & is_tmap;
      supported_o <= valid_i & is_ok;
      unsupported_o <= valid_i & ~is_ok;
    end
  end

endmodule

`default_nettype wire

// file: core/msc_framer.sv
// Segment control framer: prefixes outgoing MAC frames with the three-octet
// segment control field and strips and decodes it from incoming frames.
// Assumes the upper MAC streams frame bytes from frame control onward and
// that the PHY receive stream cannot be stalled.
// Behaviour
// R1: Every transmitted frame starts with three segment control octets.
// R2: Standard MAC header, payload and check sequence follow, passed through.
// R3: Byte 0 holds reserved, tone-map request, priority and last-segment bits.
// R4: Byte 0 bit 2 selects contention access or contention-free slot.
// R5: Six-bit count in byte 1 top; ten-bit length across bytes 1 and 2.
// R6: Bytes go to and come from the PHY first byte first.
// R7: Bit 0 of each field is its least significant bit.
// R8: Only listed command frames may be sent; others are flagged.
// R9: Beacon request is both sendable and recognised on reception.
// R10: Association and disassociation commands are never sent.
// R11: Conflict, orphan, data request and realignment commands are never sent.
// R12: Guaranteed slot requests are never sent.
// R13: A received tone-map request raises a tone-map response request.
// R14: Reserved bits go out as zero and are ignored on reception.
`timescale 1ns/1ps
`default_nettype none

module msc_framer (
  input wire logic CLK_I,                  // Clock, 125 MHz.
  input wire logic RST_N_I,                // Synchronous reset, active low.
  input wire logic TX_START_I,             // Pulse: begin a frame.
  input wire logic TX_IS_CMD_I,            // Frame is a MAC command.
  input wire logic [7:0] TX_CMD_ID_I,      // Command identifier.
  input wire logic TX_TMR_I,               // Tone map request flag.
  input wire logic TX_CC_I,                // Contention control bit.
  input wire logic TX_CAP_I,               // Access priority bit.
  input wire logic TX_LSF_I,               // Final segment flag.
  input wire logic [5:0] TX_COUNT_I,       // Segment counter.
  input wire logic [9:0] TX_LEN_I,         // Segment length field.
  input wire logic [7:0] TX_DATA_I,        // MAC frame byte.
  input wire logic TX_VALID_I,             // MAC byte valid.
  input wire logic TX_LAST_I,              // MAC byte is the last.
  output logic TX_READY_O,                 // Framer takes a MAC byte.
  output logic TX_BUSY_O,                  // Frame in progress.
  output logic TX_REJECT_O,                // Pulse: command refused.
  output logic [7:0] PHY_TX_DATA_O,        // Byte to PHY.
  output logic PHY_TX_VALID_O,             // Byte to PHY valid.
  output logic PHY_TX_LAST_O,              // Last byte of frame.
  input wire logic PHY_TX_READY_I,         // PHY takes the byte.
  input wire logic [7:0] PHY_RX_DATA_I,    // Byte from PHY.
  input wire logic PHY_RX_VALID_I,         // Byte from PHY valid.
  input wire logic PHY_RX_LAST_I,          // Last byte from PHY.
  output logic RX_HDR_VALID_O,             // Pulse: fields below updated.
  output logic RX_TMR_O,                   // Tone map request flag.
  output logic RX_CC_O,                    // Contention control bit.
  output logic RX_CAP_O,                   // Access priority bit.
  output logic RX_LSF_O,                   // Final segment flag.
  output logic [5:0] RX_COUNT_O,           // Segment counter.
  output logic [9:0] RX_LEN_O,             // Segment length field.
  output logic [7:0] RX_DATA_O,            // MAC byte to upper MAC.
  output logic RX_VALID_O,                 // MAC byte valid.
  output logic RX_LAST_O,                  // Last MAC byte.
  output logic RX_RUNT_O,                  // Pulse: frame ended in header.
  output logic TMAP_RESP_REQ_O,            // Pulse: answer with tone map.
  input wire logic RX_CMD_ID_VALID_I,      // Received command id present.
  input wire logic [7:0] RX_CMD_ID_I,      // Received command id.
  output logic RX_BEACON_REQ_O,            // Pulse: beacon request seen.
  output logic RX_CMD_UNSUPP_O             // Pulse: unsupported command.
);

  //////////////////////////////////////////////////////////////////////////
  // Command classification for both directions.

  logic tx_cls_ok;
  logic tx_cls_bad;

  // R8: classify outgoing command
  msc_cmd_class u_tx_class (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .valid_i(TX_START_I & TX_IS_CMD_I),
    .id_i(TX_CMD_ID_I),
    .beacon_o(),
    .tone_map_o(),
    .supported_o(tx_cls_ok),
    .unsupported_o(tx_cls_bad)
  );

  // R9: recognise received beacon request
  msc_cmd_class u_rx_class (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .valid_i(RX_CMD_ID_VALID_I),
    .id_i(RX_CMD_ID_I),
    .beacon_o(RX_BEACON_REQ_O),
    .tone_map_o(),
    .supported_o(),
    .unsupported_o(RX_CMD_UNSUPP_O)
  );

  //////////////////////////////////////////////////////////////////////////
  // Transmit path.

  msc_pkg::msc_tx_state_t tx_state_r, tx_state_nxt;
  logic [7:0] sc0_r, sc1_r, sc2_r;
  logic [7:0] sc0_nxt, sc1_nxt, sc2_nxt;
  logic is_cmd_r;

  // R3: pack byte 0 flags
  // R4: contention control at bit 2
  // R14: reserved bits sent as zero
  assign sc0_nxt = {msc_pkg::RSV_ZERO, TX_TMR_I, TX_CC_I, TX_CAP_I, TX_LSF_I};
  // R5: count and length split
  // R7: field bit 0 lands in the lowest bit
  assign sc1_nxt = {TX_COUNT_I, TX_LEN_I[msc_pkg::LEN_W-1:msc_pkg::LEN_LO_W]};
  assign sc2_nxt = TX_LEN_I[msc_pkg::LEN_LO_W-1:0];

  // The output byte register is refilled only when empty or draining, so
  // TX_READY_O can stay a flop at the price of a bubble after every body byte.
  wire can_load = ~PHY_TX_VALID_O | PHY_TX_READY_I;
  wire in_hdr = (tx_state_r == msc_pkg::TX_SC0) |
                (tx_state_r == msc_pkg::TX_SC1) |
                (tx_state_r == msc_pkg::TX_SC2);
  wire body_take = (tx_state_r == msc_pkg::TX_BODY) & TX_VALID_I & TX_READY_O;
  wire load = can_load & (in_hdr | body_take);
  wire start_ok = TX_START_I & (tx_state_r == msc_pkg::TX_IDLE);

  // R1: header octets precede the MAC bytes
  // R6: earliest octet first
  // R2: MAC bytes pass through unchanged
  wire [7:0] tx_byte = (tx_state_r == msc_pkg::TX_SC0) ? sc0_r :
                       (tx_state_r == msc_pkg::TX_SC1) ? sc1_r :
                       (tx_state_r == msc_pkg::TX_SC2) ? sc2_r : TX_DATA_I;
  wire ov_nxt = can_load ? load : PHY_TX_VALID_O;
  wire [7:0] od_nxt = load ? tx_byte : PHY_TX_DATA_O;
  wire ol_nxt = load ? (body_take & TX_LAST_I) : PHY_TX_LAST_O;

  // Transmit sequencing; commands wait one cycle for their verdict.
  always_comb begin
    tx_state_nxt = tx_state_r;
    unique case (tx_state_r)
      msc_pkg::TX_IDLE: begin
        if (TX_START_I) begin
          tx_state_nxt = TX_IS_CMD_I ? msc_pkg::TX_CHECK : msc_pkg::TX_SC0;
        end
      end
      // R10: forbidden commands stopped here
      // R11: not generated commands stopped here
      // R12: slot requests stopped here
      msc_pkg::TX_CHECK: begin
        tx_state_nxt = tx_cls_ok ? msc_pkg::TX_SC0 : msc_pkg::TX_IDLE;
      end
      msc_pkg::TX_SC0: begin
        if (can_load) tx_state_nxt = msc_pkg::TX_SC1;
      end
      msc_pkg::TX_SC1: begin
        if (can_load) tx_state_nxt = msc_pkg::TX_SC2;
      end
      msc_pkg::TX_SC2: begin
        if (can_load) tx_state_nxt = msc_pkg::TX_BODY;
      end
      msc_pkg::TX_BODY: begin
        if (body_take & can_load & TX_LAST_I) begin
          tx_state_nxt = msc_pkg::TX_IDLE;
        end
      end
      default: tx_state_nxt = msc_pkg::TX_IDLE;
    endcase
  end

  wire ready_nxt = (tx_state_nxt == msc_pkg::TX_BODY) & ~ov_nxt;

  // Transmit registers.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      tx_state_r <= msc_pkg::TX_IDLE;
      sc0_r <= 8'h00;
      sc1_r <= 8'h00;
      sc2_r <= 8'h00;
      is_cmd_r <= 1'b0;
      TX_READY_O <= 1'b0;
      TX_BUSY_O <= 1'b0;
      TX_REJECT_O <= 1'b0;
      PHY_TX_DATA_O <= 8'h00;
      PHY_TX_VALID_O <= 1'b0;
      PHY_TX_LAST_O <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      if (start_ok) begin
        sc0_r <= sc0_nxt;
        sc1_r <= sc1_nxt;
        sc2_r <= sc2_nxt;
        is_cmd_r <= TX_IS_CMD_I;
      end
      TX_READY_O <= ready_nxt;
      TX_BUSY_O <= (tx_state_nxt != msc_pkg::TX_IDLE);
      TX_REJECT_O <= (tx_state_r == msc_pkg::TX_CHECK) & tx_cls_bad;
      PHY_TX_DATA_O <= od_nxt;
      PHY_TX_VALID_O <= ov_nxt;
      PHY_TX_LAST_O <= ol_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive path.

  msc_pkg::msc_rx_state_t rx_state_r, rx_state_nxt;
  logic [7:0] rb0_r, rb1_r;
  logic tmr_seen_r;

  wire rx_hdr_end = PHY_RX_VALID_I & (rx_state_r == msc_pkg::RX_SC2);
  wire rx_body = PHY_RX_VALID_I & (rx_state_r == msc_pkg::RX_BODY);
  wire rx_runt = PHY_RX_VALID_I & PHY_RX_LAST_I &
                 (rx_state_r != msc_pkg::RX_BODY);

  // R6: first received octets are segment control
  always_comb begin
    rx_state_nxt = rx_state_r;
    unique case (rx_state_r)
      msc_pkg::RX_SC0: if (PHY_RX_VALID_I) rx_state_nxt = msc_pkg::RX_SC1;
      msc_pkg::RX_SC1: if (PHY_RX_VALID_I) rx_state_nxt = msc_pkg::RX_SC2;
      msc_pkg::RX_SC2: if (PHY_RX_VALID_I) rx_state_nxt = msc_pkg::RX_BODY;
      msc_pkg::RX_BODY: if (PHY_RX_VALID_I) rx_state_nxt = rx_state_r;
    endcase
    if (PHY_RX_VALID_I & PHY_RX_LAST_I) rx_state_nxt = msc_pkg::RX_SC0;
  end

  // Header bytes are held internally so the decoded outputs change only
  // together with RX_HDR_VALID_O.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rx_state_r <= msc_pkg::RX_SC0;
      rb0_r <= 8'h00;
      rb1_r <= 8'h00;
    end else begin
      rx_state_r <= rx_state_nxt;
      if (PHY_RX_VALID_I & (rx_state_r == msc_pkg::RX_SC0)) rb0_r <= PHY_RX_DATA_I;
      if (PHY_RX_VALID_I & (rx_state_r == msc_pkg::RX_SC1)) rb1_r <= PHY_RX_DATA_I;
    end
  end

  // Decoded fields; runt frames leave the previous header in place.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RX_HDR_VALID_O <= 1'b0;
      RX_TMR_O <= 1'b0;
      RX_CC_O <= 1'b0;
      RX_CAP_O <= 1'b0;
      RX_LSF_O <= 1'b0;
      RX_COUNT_O <= 6'h00;
      RX_LEN_O <= 10'h000;
    end else begin
      RX_HDR_VALID_O <= rx_hdr_end & ~PHY_RX_LAST_I;
      if (rx_hdr_end & ~PHY_RX_LAST_I) begin
        // R3: unpack byte 0 flags
        // R4: contention control bit
        // R14: reserved bits ignored
        RX_TMR_O <= rb0_r[msc_pkg::TMR_BIT];
        RX_CC_O <= rb0_r[msc_pkg::CC_BIT];
        RX_CAP_O <= rb0_r[msc_pkg::CAP_BIT];
        RX_LSF_O <= rb0_r[msc_pkg::LSF_BIT];
        // R5: count and length rejoined
        // R7: top bits most significant
        RX_COUNT_O <= rb1_r[msc_pkg::CNT_HI:msc_pkg::CNT_LO];
        RX_LEN_O <= {rb1_r[msc_pkg::LEN_TOP_HI:msc_pkg::LEN_TOP_LO],
                     PHY_RX_DATA_I};
      end
    end
  end

  // Body pass-through and end-of-frame events.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RX_DATA_O <= 8'h00;
      RX_VALID_O <= 1'b0;
      RX_LAST_O <= 1'b0;
      RX_RUNT_O <= 1'b0;
      TMAP_RESP_REQ_O <= 1'b0;
      tmr_seen_r <= 1'b0;
    end else begin
      // R2: MAC bytes handed up unchanged
      RX_VALID_O <= rx_body;
      RX_LAST_O <= rx_body & PHY_RX_LAST_I;
      if (rx_body) RX_DATA_O <= PHY_RX_DATA_I;
      RX_RUNT_O <= rx_runt;
      if (rx_hdr_end) tmr_seen_r <= rb0_r[msc_pkg::TMR_BIT];
      // R13: request a tone-map answer
      TMAP_RESP_REQ_O <= rx_body & PHY_RX_LAST_I & tmr_seen_r;
    end
  end

endmodule

`default_nettype wire

// file: verification/msc_framer_props.sv
// Port-level checker for the segment control framer.
// Assumes one clock and the framer's active low synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module msc_framer_props (
  input wire logic CLK_I, // Clock.
  input wire logic RST_N_I, // Reset.
  input wire logic TX_START_I, // Start.
  input wire logic TX_IS_CMD_I, // Command.
  input wire logic [7:0] TX_CMD_ID_I, // Id.
  input wire logic TX_TMR_I, // Flag.
  input wire logic TX_CC_I, // Flag.
  input wire logic TX_CAP_I, // Flag.
  input wire logic TX_LSF_I, // Flag.
  input wire logic TX_BUSY_O, // Busy.
  input wire logic TX_REJECT_O, // Refused.
  input wire logic [7:0] PHY_TX_DATA_O, // Byte.
  input wire logic PHY_TX_VALID_O, // Valid.
  input wire logic PHY_TX_READY_I, // Ready.
  input wire logic RX_HDR_VALID_O, // Header.
  input wire logic RX_TMR_O, // Flag.
  input wire logic RX_LAST_O, // Last.
  input wire logic TMAP_RESP_REQ_O, // Answer.
  input wire logic RX_CMD_ID_VALID_I, // Id valid.
  input wire logic [7:0] RX_CMD_ID_I, // Id.
  input wire logic RX_BEACON_REQ_O, // Beacon.
  input wire logic RX_CMD_UNSUPP_O // Unsupported.
);
  logic tx_ok;
  logic rx_ok;
  logic go;
  // Only the two listed identifiers are legal in either direction.
  assign tx_ok = TX_CMD_ID_I == msc_pkg::CMD_BEACON_REQ ||
    TX_CMD_ID_I == msc_pkg::CMD_TONE_MAP_RESP;
  assign rx_ok = RX_CMD_ID_I == msc_pkg::CMD_BEACON_REQ ||
    RX_CMD_ID_I == msc_pkg::CMD_TONE_MAP_RESP;
  assign go = TX_START_I && !TX_BUSY_O;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////////////
  tx_first_octet_a: assert property (go && !TX_IS_CMD_I |=> TX_BUSY_O
    ##1 PHY_TX_VALID_O && PHY_TX_DATA_O == {4'h0, $past(TX_TMR_I, 2),
    $past(TX_CC_I, 2), $past(TX_CAP_I, 2), $past(TX_LSF_I, 2)})
    else $error("first octet wrong");
  cmd_refused_a: assert property (go && TX_IS_CMD_I && !tx_ok
    |=> !PHY_TX_VALID_O ##1 TX_REJECT_O && !PHY_TX_VALID_O)
    else $error("bad command not refused");
  cmd_accepted_a: assert property (go && TX_IS_CMD_I && tx_ok
    |=> !TX_REJECT_O [*2] ##1 PHY_TX_VALID_O)
    else $error("listed command not sent");
  phy_byte_hold_a: assert property (PHY_TX_VALID_O && !PHY_TX_READY_I
    |=> PHY_TX_VALID_O && $stable(PHY_TX_DATA_O))
    else $error("phy byte dropped");
  reject_pulse_a: assert property (TX_REJECT_O
    |=> !TX_REJECT_O && !PHY_TX_VALID_O) else $error("reject not a pulse");
  rx_beacon_seen_a: assert property (RX_CMD_ID_VALID_I
    && RX_CMD_ID_I == msc_pkg::CMD_BEACON_REQ
    |=> RX_BEACON_REQ_O && !RX_CMD_UNSUPP_O) else $error("beacon missed");
  rx_unsupp_flag_a: assert property (RX_CMD_ID_VALID_I
    |=> RX_CMD_UNSUPP_O == !$past(rx_ok)) else $error("unsupported flag");
  tone_map_answer_a: assert property (TMAP_RESP_REQ_O
    |-> RX_LAST_O && RX_TMR_O) else $error("tone map answer wrong");
  header_pulse_a: assert property (RX_HDR_VALID_O
    |=> !RX_HDR_VALID_O) else $error("header pulse too long");
  reset_quiet_a: assert property (disable iff (1'b0) !RST_N_I
    |=> !PHY_TX_VALID_O && !TX_BUSY_O) else $error("active in reset");
  // Main scenarios reached.
  cover property (go && !TX_IS_CMD_I);
  cover property (TX_REJECT_O);
  cover property (TMAP_RESP_REQ_O);
endmodule
bind msc_framer msc_framer_props chk (.CLK_I, .RST_N_I, .TX_START_I,
  .TX_IS_CMD_I, .TX_CMD_ID_I, .TX_TMR_I, .TX_CC_I, .TX_CAP_I, .TX_LSF_I,
  .TX_BUSY_O, .TX_REJECT_O, .PHY_TX_DATA_O, .PHY_TX_VALID_O,
  .PHY_TX_READY_I, .RX_HDR_VALID_O, .RX_TMR_O, .RX_LAST_O,
  .TMAP_RESP_REQ_O, .RX_CMD_ID_VALID_I, .RX_CMD_ID_I, .RX_BEACON_REQ_O,
  .RX_CMD_UNSUPP_O);
`default_nettype wire

// file: verification/msc_phy_model.sv
// Behavioural PHY: captures sent bytes and plays received bytes.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module msc_phy_model (
  input wire logic clk_i, // Clock.
  input wire logic stall_i, // Ready only every other cycle.
  input wire logic [7:0] tx_data_i, // Byte from framer.
  input wire logic tx_valid_i, // Byte valid.
  input wire logic tx_last_i, // Last byte.
  output logic tx_ready_o, // Byte taken.
  output logic [7:0] rx_data_o, // Byte to framer.
  output logic rx_valid_o, // Byte valid.
  output logic rx_last_o // Last byte.
);
  logic [7:0] got [0:63];
  int got_n = 0;
  int lasts = 0;
  initial begin
    tx_ready_o = 1'b1;
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got[got_n] = tx_data_i;
      got_n++;
      lasts += int'(tx_last_i);
    end
    tx_ready_o <= #1 stall_i ? !tx_ready_o : 1'b1;
  end
  task automatic rx_byte(input logic [7:0] b, input logic last);
    @(posedge clk_i);
    #1;
    rx_data_o = b;
    rx_valid_o = 1'b1;
    rx_last_o = last;
  endtask
  // Idle line shows the inverse so a stale byte is never mistaken.
  task automatic rx_idle();
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
endmodule
`default_nettype wire

// file: verification/mac_segment_control_framer_tb_top.sv
// Self-checking bench for the segment control framer.
// Assumes the PHY model file and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module mac_segment_control_framer_tb_top;
  // Signals carry the port names so the instance connects by name briefly.
  logic CLK_I, RST_N_I, TX_START_I, TX_IS_CMD_I, TX_TMR_I, TX_CC_I;
  logic TX_CAP_I, TX_LSF_I, TX_VALID_I, TX_LAST_I, TX_READY_O, TX_BUSY_O;
  logic TX_REJECT_O, PHY_TX_VALID_O, PHY_TX_LAST_O, PHY_TX_READY_I;
  logic PHY_RX_VALID_I, PHY_RX_LAST_I, RX_HDR_VALID_O, RX_TMR_O, RX_CC_O;
  logic RX_CAP_O, RX_LSF_O, RX_VALID_O, RX_LAST_O, RX_RUNT_O, stall;
  logic TMAP_RESP_REQ_O, RX_CMD_ID_VALID_I, RX_BEACON_REQ_O, RX_CMD_UNSUPP_O;
  logic [7:0] TX_CMD_ID_I, TX_DATA_I, PHY_TX_DATA_O, PHY_RX_DATA_I;
  logic [7:0] RX_DATA_O, RX_CMD_ID_I, rx_last_byte;
  logic [5:0] TX_COUNT_I, RX_COUNT_O;
  logic [9:0] TX_LEN_I, RX_LEN_O;
  logic [19:0] hdr_seen;
  int error_cnt = 0;
  int check_count = 0;
  int body_n = 0;
  int tmap_n = 0;
  int runt_n = 0;
  int rlast_n = 0;
  logic [7:0] bad_ids [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h08, 8'h09};
  msc_framer dut (.*);
  msc_phy_model phy (.clk_i(CLK_I), .stall_i(stall),
    .tx_data_i(PHY_TX_DATA_O), .tx_valid_i(PHY_TX_VALID_O),
    .tx_last_i(PHY_TX_LAST_O), .tx_ready_o(PHY_TX_READY_I),
    .rx_data_o(PHY_RX_DATA_I), .rx_valid_o(PHY_RX_VALID_I),
    .rx_last_o(PHY_RX_LAST_I));
  ////////////////////////////////////////////////////////////////////////
  // Records what the receive side hands upward, one edge after it shows.
  always @(posedge CLK_I) begin
    if (RX_HDR_VALID_O === 1'b1) begin
      hdr_seen = {RX_TMR_O, RX_CC_O, RX_CAP_O, RX_LSF_O, RX_COUNT_O, RX_LEN_O};
    end
    if (RX_VALID_O === 1'b1) begin
      body_n++;
      rx_last_byte = RX_DATA_O;
    end
    tmap_n += int'(TMAP_RESP_REQ_O === 1'b1);
    runt_n += int'(RX_RUNT_O === 1'b1);
    rlast_n += int'(RX_LAST_O === 1'b1);
  end
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  initial begin
    repeat (20000) @(posedge CLK_I);
    error_cnt++;
    give_verdict();
  end
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Sends one frame and compares every byte the PHY captured.
  task automatic tx_frame(input logic cmd, input logic [7:0] id,
      input logic [3:0] fl, input logic [5:0] cnt, input logic [9:0] len,
      input int n);
    int base;
    int l0;
    int k;
    logic [7:0] e;
    base = phy.got_n;
    l0 = phy.lasts;
    TX_IS_CMD_I = cmd;
    TX_CMD_ID_I = id;
    {TX_TMR_I, TX_CC_I, TX_CAP_I, TX_LSF_I} = fl;
    TX_COUNT_I = cnt;
    TX_LEN_I = len;
    TX_START_I = 1'b1;
    @(posedge CLK_I);
    #1;
    TX_START_I = 1'b0;
    for (int i = 0; i < n; i++) begin
      TX_DATA_I = 8'h40 + 8'(i);
      TX_VALID_I = 1'b1;
      TX_LAST_I = (i == n - 1);
      k = 0;
      while (TX_READY_O !== 1'b1 && k < 50) begin
        @(posedge CLK_I);
        #1;
        k++;
      end
      if (k == 50) check("tx ready wait", 32'h0, 32'h1);
      @(posedge CLK_I);
      #1;
    end
    TX_VALID_I = 1'b0;
    k = 0;
    while (phy.lasts == l0 && k < 100) begin
      @(posedge CLK_I);
      k++;
    end
    #1;
    check("phy byte count", 32'(n + 3), 32'(phy.got_n - base));
    check("phy last count", 32'h1, 32'(phy.lasts - l0));
    for (int j = 0; j < n + 3; j++) begin
      case (j)
        0: e = {msc_pkg::RSV_ZERO, fl};
        1: e = {cnt, len[9:8]};
        2: e = len[7:0];
        default: e = 8'h40 + 8'(j - 3);
      endcase
      check("phy byte", {24'h0, e}, {24'h0, phy.got[base + j]});
    end
    $display("tx frame test done");
  endtask
  // A command off the list must be refused and never reach the PHY.
  task automatic tx_refused(input logic [7:0] id);
    int seen;
    seen = 0;
    TX_IS_CMD_I = 1'b1;
    TX_CMD_ID_I = id;
    TX_START_I = 1'b1;
    @(posedge CLK_I);
    #1;
    TX_START_I = 1'b0;
    repeat (5) begin
      @(posedge CLK_I);
      #1;
      seen += int'(TX_REJECT_O === 1'b1) + 10 * int'(PHY_TX_VALID_O !== 1'b0);
    end
    check("refused command", 32'h1, 32'(seen));
    $display("tx refused test done");
  endtask
  // Plays a received frame with two body bytes and checks the decode.
  task automatic rx_frame(input logic [7:0] o0, input logic [7:0] o1,
      input logic [7:0] o2, input logic [19:0] hdr, input int tm);
    int b0;
    int t0;
    int e0;
    b0 = body_n;
    t0 = tmap_n;
    e0 = rlast_n;
    phy.rx_byte(o0, 1'b0);
    phy.rx_byte(o1, 1'b0);
    phy.rx_byte(o2, 1'b0);
    phy.rx_byte(8'h80, 1'b0);
    phy.rx_byte(8'h81, 1'b1);
    phy.rx_idle();
    repeat (3) @(posedge CLK_I);
    #1;
    check("rx header", {12'h0, hdr}, {12'h0, hdr_seen});
    check("rx body", 32'h2, 32'(body_n - b0));
    check("rx last byte", 32'h81, {24'h0, rx_last_byte});
    check("rx last pulses", 32'h1, 32'(rlast_n - e0));
    check("tone map answers", 32'(tm), 32'(tmap_n - t0));
    $display("rx frame test done");
  endtask
  // A frame cut inside the header must flag a runt and change nothing else.
  task automatic rx_runt();
    int b0;
    int r0;
    logic [19:0] h0;
    b0 = body_n;
    r0 = runt_n;
    h0 = hdr_seen;
    phy.rx_byte(8'h0f, 1'b0);
    phy.rx_byte(8'hff, 1'b1);
    phy.rx_idle();
    repeat (3) @(posedge CLK_I);
    #1;
    check("rx runt", 32'h1, 32'(runt_n - r0));
    check("rx runt body", 32'h0, 32'(body_n - b0));
    check("rx runt header", {12'h0, h0}, {12'h0, hdr_seen});
    $display("rx runt test done");
  endtask
  // Received command identifiers sorted into beacon, listed, unsupported.
  task automatic rx_cmd(input logic [7:0] id, input logic [1:0] exp);
    RX_CMD_ID_I = id;
    RX_CMD_ID_VALID_I = 1'b1;
    @(posedge CLK_I);
    #1;
    RX_CMD_ID_VALID_I = 1'b0;
    check("rx class", {30'h0, exp}, {30'h0, RX_BEACON_REQ_O,
      RX_CMD_UNSUPP_O});
    $display("rx command test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {TX_START_I, TX_IS_CMD_I, TX_TMR_I, TX_CC_I, TX_CAP_I} = '0;
    {TX_LSF_I, TX_VALID_I, TX_LAST_I, RX_CMD_ID_VALID_I, stall} = '0;
    {TX_CMD_ID_I, TX_DATA_I, RX_CMD_ID_I, TX_COUNT_I, TX_LEN_I} = '0;
    RST_N_I = 1'b0;
    repeat (3) @(posedge CLK_I);
    #1;
    RST_N_I = 1'b1;
    tx_frame(1'b0, 8'h00, 4'ha, 6'h2a, 10'h2c5, 4);
    stall = 1'b1;
    tx_frame(1'b0, 8'h00, 4'h5, 6'h3f, 10'h3ff, 3);
    stall = 1'b0;
    tx_frame(1'b1, msc_pkg::CMD_BEACON_REQ, 4'h1, 6'h01, 10'h001, 2);
    tx_frame(1'b1, msc_pkg::CMD_TONE_MAP_RESP, 4'h8, 6'h00, 10'h100, 1);
    foreach (bad_ids[i]) tx_refused(bad_ids[i]);
    rx_frame(8'hf9, 8'h56, 8'h5a, {4'h9, 6'h15, 10'h25a}, 1);
    rx_runt();
    rx_frame(8'h06, 8'hfc, 8'h00, {4'h6, 6'h3f, 10'h000}, 0);
    rx_cmd(8'h07, 2'b10);
    rx_cmd(8'h0a, 2'b00);
    rx_cmd(8'h01, 2'b01);
    rx_cmd(8'h09, 2'b01);
    give_verdict();
  end
endmodule
`default_nettype wire
